// *** verilog/flying_press_sequencer.sv ***
`timescale 1ns/1ps
module flying_press_sequencer #(
	parameter int MS_CYCLES = press_seq_pkg::MS_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	output logic irq,
	input wire logic die_jog_fwd,
	input wire logic die_jog_rev,
	input wire logic run_in,
	input wire logic press_complete,
	input wire logic manual_cycle,
	input wire logic die_retract,
	input wire logic hole_detect,
	input wire logic estop_ready,
	input wire logic ref_switch,
	input wire logic line_step,
	input wire logic line_dir,
	input wire logic die_step,
	input wire logic die_dir,
	input wire logic cfg_switch_one,
	input wire logic cfg_switch_two,
	input wire logic cfg_switch_three,
	input wire logic line_encoder_dir_switch,
	input wire logic die_encoder_dir_switch,
	input wire logic drive_polarity_switch,
	input wire logic spare_switch,
	output logic press_down,
	output logic drive_enable,
	output logic run_out,
	output logic die_fwd,
	output logic die_rev
);
	press_seq_pkg::state_type state_reg, state_next;
	logic [15:0] qty_reg, holes_reg, length_set_reg, test_len_reg, test_vel_reg, hold_reg, left_reg, hole_cnt_reg;
	logic [23:0] min_die_reg, length_reg, die_pos_reg, target_reg;
	localparam int EV_W = press_seq_pkg::EV_WIDTH;
	logic [EV_W-1:0] irq_status_reg, irq_enable_reg, ev;
	logic [7:0] unit_id_reg;
	logic order_loaded_reg, test_mode_reg, armed_reg, referenced_reg, ref_err_reg;
	logic hole_prev_reg, run_prev_reg, cycle_prev_reg;
	logic [31:0] ms_cnt_reg;
	logic [15:0] hold_cnt_reg;
	logic hole_rise, run_rise, cycle_rise, permit, fire_state, fire_done, sim_pulse, line_pulse, line_up;
	logic test_go, test_stop, order_load, clear_holes, at_target, continuous, in_ref;

	assign hole_rise = hole_detect & ~hole_prev_reg;
	assign run_rise = run_in & ~run_prev_reg;
	assign cycle_rise = manual_cycle & ~cycle_prev_reg;
	assign permit = estop_ready & ~spare_switch;
	assign test_go = wr_stb && addr == press_seq_pkg::ADDR_CTRL && wdata[press_seq_pkg::CTRL_TEST_START];
	assign test_stop = wr_stb && addr == press_seq_pkg::ADDR_CTRL && wdata[press_seq_pkg::CTRL_TEST_CANCEL];
	assign order_load = wr_stb && addr == press_seq_pkg::ADDR_CTRL && wdata[press_seq_pkg::CTRL_ORDER_LOAD];
	assign clear_holes = wr_stb && addr == press_seq_pkg::ADDR_CTRL && wdata[press_seq_pkg::CTRL_CLEAR_HOLES];
	assign fire_state = state_reg == press_seq_pkg::ST_REF_FIRE || state_reg == press_seq_pkg::ST_CUT ||
		state_reg == press_seq_pkg::ST_FIRE;
	assign in_ref = state_reg == press_seq_pkg::ST_REF_SEEK || state_reg == press_seq_pkg::ST_REF_MOVE ||
		state_reg == press_seq_pkg::ST_REF_FIRE || state_reg == press_seq_pkg::ST_REF_HOME;
	assign fire_done = press_complete || hold_cnt_reg >= hold_reg;
	assign at_target = armed_reg && $signed(length_reg) >= $signed(target_reg);
	assign continuous = qty_reg == press_seq_pkg::QTY_CONTINUOUS;

	pulse_rate_gen sim_gen (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(test_mode_reg && state_reg != press_seq_pkg::ST_IDLE),
		.rate(test_vel_reg),
		.pulse(sim_pulse)
	);
	assign line_pulse = test_mode_reg ? sim_pulse : line_step;
	assign line_up = test_mode_reg ? 1'b1 : line_dir ^ line_encoder_dir_switch;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			press_seq_pkg::ST_IDLE: begin
				if (cycle_rise) begin
					state_next = permit ? press_seq_pkg::ST_REF_SEEK : press_seq_pkg::ST_CUT;
				end else if (test_go && permit) begin
					state_next = press_seq_pkg::ST_RUN;
				end else if (run_rise && order_loaded_reg && permit) begin
					state_next = press_seq_pkg::ST_RUN;
				end
			end
			press_seq_pkg::ST_REF_SEEK: begin
				if (ref_switch) begin
					state_next = press_seq_pkg::ST_REF_MOVE;
				end
			end
			press_seq_pkg::ST_REF_MOVE: begin
				if ($signed(die_pos_reg) >= $signed(min_die_reg)) begin
					state_next = press_seq_pkg::ST_REF_FIRE;
				end
			end
			press_seq_pkg::ST_REF_FIRE: begin
				if (fire_done) begin
					state_next = press_seq_pkg::ST_REF_HOME;
				end
			end
			press_seq_pkg::ST_REF_HOME: begin
				if (ref_switch) begin
					state_next = press_seq_pkg::ST_IDLE;
				end
			end
			press_seq_pkg::ST_CUT: begin
				if (fire_done) begin
					state_next = press_seq_pkg::ST_IDLE;
				end
			end
			press_seq_pkg::ST_RUN: begin
				if (test_mode_reg ? test_stop : ~run_in) begin
					state_next = press_seq_pkg::ST_IDLE;
				end else if (at_target) begin
					state_next = press_seq_pkg::ST_FIRE;
				end
			end
			press_seq_pkg::ST_FIRE: begin
				if (test_mode_reg && test_stop) begin
					state_next = press_seq_pkg::ST_IDLE;
				end else if (fire_done) begin
					state_next = press_seq_pkg::ST_RETURN;
				end
			end
			press_seq_pkg::ST_RETURN: begin
				if (test_mode_reg && test_stop) begin
					state_next = press_seq_pkg::ST_IDLE;
				end else if (ref_switch) begin
					state_next = (!test_mode_reg && !continuous && left_reg == 16'h0000) ?
						press_seq_pkg::ST_IDLE : press_seq_pkg::ST_RUN;
				end
			end
			default: state_next = press_seq_pkg::ST_IDLE;
		endcase
		if (in_ref && !manual_cycle) begin
			state_next = press_seq_pkg::ST_IDLE;
		end
		if (!permit && state_next != press_seq_pkg::ST_CUT) begin
			state_next = press_seq_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= press_seq_pkg::ST_IDLE;
			hole_prev_reg <= 1'b0;
			run_prev_reg <= 1'b0;
			cycle_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			hole_prev_reg <= hole_detect;
			run_prev_reg <= run_in;
			cycle_prev_reg <= manual_cycle;
		end
	end

	// Millisecond base for the cut hold timer.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ms_cnt_reg <= 32'h00000000;
			hold_cnt_reg <= 16'h0000;
		end else if (!fire_state) begin
			ms_cnt_reg <= 32'h00000000;
			hold_cnt_reg <= 16'h0000;
		end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= 32'h00000000;
			hold_cnt_reg <= hold_cnt_reg + 16'h0001;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			length_reg <= 24'h000000;
			referenced_reg <= 1'b0;
		end else if (state_reg == press_seq_pkg::ST_REF_FIRE && press_complete) begin
			length_reg <= 24'h000000;
			referenced_reg <= 1'b1;
		end else begin
			if (state_reg == press_seq_pkg::ST_REF_SEEK) begin
				referenced_reg <= 1'b0;
			end
			if (line_pulse) begin
				length_reg <= line_up ? length_reg + 24'h000001 : length_reg - 24'h000001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			die_pos_reg <= 24'h000000;
		end else if (state_reg == press_seq_pkg::ST_REF_SEEK && ref_switch) begin
			die_pos_reg <= 24'h000000;
		end else if (die_step) begin
			die_pos_reg <= (die_dir ^ die_encoder_dir_switch) ? die_pos_reg + 24'h000001 :
				die_pos_reg - 24'h000001;
		end
	end

	// Hole counter, targets and batch count.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hole_cnt_reg <= 16'h0000;
			armed_reg <= 1'b0;
			target_reg <= 24'h000000;
			left_reg <= 16'h0000;
			order_loaded_reg <= 1'b0;
			test_mode_reg <= 1'b0;
		end else begin
			if (state_reg == press_seq_pkg::ST_IDLE && state_next == press_seq_pkg::ST_RUN) begin
				test_mode_reg <= ~(run_rise && order_loaded_reg) | test_go;
			end else if (state_next == press_seq_pkg::ST_IDLE) begin
				test_mode_reg <= 1'b0;
			end
			if (order_load) begin
				left_reg <= qty_reg;
				order_loaded_reg <= qty_reg != 16'h0000;
			end else if (state_reg == press_seq_pkg::ST_FIRE && fire_done && !test_mode_reg && !continuous &&
					left_reg != 16'h0000) begin
				left_reg <= left_reg - 16'h0001;
				order_loaded_reg <= left_reg != 16'h0001;
			end
			if (clear_holes || state_reg == press_seq_pkg::ST_FIRE) begin
				hole_cnt_reg <= 16'h0000;
				armed_reg <= 1'b0;
			end else if (state_reg == press_seq_pkg::ST_IDLE && state_next == press_seq_pkg::ST_RUN && at_target) begin
				armed_reg <= 1'b0;
			end else if (test_mode_reg && state_reg == press_seq_pkg::ST_RUN && !armed_reg) begin
				target_reg <= length_reg + {8'h00, test_len_reg};
				armed_reg <= 1'b1;
			end else if (!test_mode_reg && hole_rise && state_reg != press_seq_pkg::ST_IDLE && !armed_reg) begin
				if (hole_cnt_reg + 16'h0001 >= holes_reg) begin
					hole_cnt_reg <= 16'h0000;
					target_reg <= length_reg + {8'h00, length_set_reg};
					armed_reg <= 1'b1;
				end else begin
					hole_cnt_reg <= hole_cnt_reg + 16'h0001;
				end
			end
		end
	end

	always_comb begin
		ev = '0;
		ev[press_seq_pkg::EV_REF_DONE] = state_reg == press_seq_pkg::ST_REF_HOME &&
			state_next == press_seq_pkg::ST_IDLE && ref_switch && manual_cycle && permit;
		ev[press_seq_pkg::EV_REF_ERROR] = in_ref && !manual_cycle;
		ev[press_seq_pkg::EV_MISSED_CUT] = state_reg == press_seq_pkg::ST_IDLE &&
			state_next == press_seq_pkg::ST_RUN && at_target;
		ev[press_seq_pkg::EV_PIECE_DONE] = state_reg == press_seq_pkg::ST_FIRE && fire_done;
		ev[press_seq_pkg::EV_BATCH_DONE] = state_reg == press_seq_pkg::ST_RETURN &&
			state_next == press_seq_pkg::ST_IDLE && ref_switch && !test_mode_reg;
	end

	// Register writes; a new event wins over a clear in the same cycle.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			qty_reg <= 16'h0000;
			holes_reg <= press_seq_pkg::HOLES_RESET;
			length_set_reg <= 16'h0000;
			test_len_reg <= 16'h0000;
			test_vel_reg <= 16'h0000;
			hold_reg <= press_seq_pkg::HOLD_MS_RESET;
			min_die_reg <= press_seq_pkg::MIN_DIE_RESET;
			irq_enable_reg <= '0;
			irq_status_reg <= '0;
		end else begin
			if (wr_stb) begin
				case (addr)
					press_seq_pkg::ADDR_QTY: qty_reg <= wdata[15:0];
					press_seq_pkg::ADDR_HOLES: holes_reg <= wdata[15:0];
					press_seq_pkg::ADDR_LENGTH: length_set_reg <= wdata[15:0];
					press_seq_pkg::ADDR_TEST_LEN: test_len_reg <= wdata[15:0];
					press_seq_pkg::ADDR_TEST_VEL: test_vel_reg <= wdata[15:0];
					press_seq_pkg::ADDR_HOLD: hold_reg <= wdata[15:0];
					press_seq_pkg::ADDR_MIN_DIE: min_die_reg <= wdata[23:0];
					press_seq_pkg::ADDR_IRQ_ENABLE: irq_enable_reg <= wdata[EV_W-1:0];
					default: ;
				endcase
			end
			irq_status_reg <= (irq_status_reg & ~((wr_stb && addr == press_seq_pkg::ADDR_IRQ_CLEAR) ?
				wdata[EV_W-1:0] : '0)) | ev;
		end
	end

	// Registered outputs and read port.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
			irq <= 1'b0;
			unit_id_reg <= press_seq_pkg::UNIT_ID_BASE;
			press_down <= 1'b0;
			drive_enable <= 1'b0;
			run_out <= 1'b0;
			die_fwd <= 1'b0;
			die_rev <= 1'b0;
		end else begin
			irq <= |(irq_status_reg & irq_enable_reg);
			unit_id_reg <= press_seq_pkg::UNIT_ID_BASE + {5'h00, cfg_switch_three, cfg_switch_two, cfg_switch_one};
			press_down <= state_next == press_seq_pkg::ST_REF_FIRE || state_next == press_seq_pkg::ST_CUT ||
				state_next == press_seq_pkg::ST_FIRE;
			drive_enable <= estop_ready;
			run_out <= estop_ready && (state_next == press_seq_pkg::ST_RUN || state_next == press_seq_pkg::ST_FIRE ||
				state_next == press_seq_pkg::ST_RETURN);
			die_fwd <= drive_polarity_switch ? die_rev_cmd(state_next) : die_fwd_cmd(state_next);
			die_rev <= drive_polarity_switch ? die_fwd_cmd(state_next) : die_rev_cmd(state_next);
			rdata <= 32'h00000000;
			if (rd_stb) begin
				case (addr)
					press_seq_pkg::ADDR_QTY: rdata <= {16'h0000, qty_reg};
					press_seq_pkg::ADDR_HOLES: rdata <= {16'h0000, holes_reg};
					press_seq_pkg::ADDR_LENGTH: rdata <= {16'h0000, length_set_reg};
					press_seq_pkg::ADDR_TEST_LEN: rdata <= {16'h0000, test_len_reg};
					press_seq_pkg::ADDR_TEST_VEL: rdata <= {16'h0000, test_vel_reg};
					press_seq_pkg::ADDR_HOLD: rdata <= {16'h0000, hold_reg};
					press_seq_pkg::ADDR_MIN_DIE: rdata <= {8'h00, min_die_reg};
					press_seq_pkg::ADDR_STATUS: rdata <= {left_reg, 6'h00, spare_switch, order_loaded_reg,
						armed_reg, test_mode_reg, referenced_reg, 1'b0, state_reg};
					press_seq_pkg::ADDR_POSITION: rdata <= {8'h00, length_reg};
					press_seq_pkg::ADDR_UNIT_ID: rdata <= {24'h000000, unit_id_reg};
					press_seq_pkg::ADDR_IRQ_STATUS: rdata <= {27'h0000000, irq_status_reg};
					press_seq_pkg::ADDR_IRQ_ENABLE: rdata <= {27'h0000000, irq_enable_reg};
					default: rdata <= 32'h00000000;
				endcase
			end
		end
	end

	function automatic logic die_fwd_cmd(input press_seq_pkg::state_type s);
		die_fwd_cmd = s == press_seq_pkg::ST_REF_MOVE || s == press_seq_pkg::ST_FIRE ||
			(s == press_seq_pkg::ST_IDLE && die_jog_fwd && !die_jog_rev && !die_retract);
	endfunction

	function automatic logic die_rev_cmd(input press_seq_pkg::state_type s);
		die_rev_cmd = s == press_seq_pkg::ST_REF_SEEK || s == press_seq_pkg::ST_REF_HOME ||
			s == press_seq_pkg::ST_RETURN || (s == press_seq_pkg::ST_IDLE && (die_retract || die_jog_rev) && !die_jog_fwd);
	endfunction

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_ref_fire_end;
		state_reg == press_seq_pkg::ST_REF_FIRE && fire_done && manual_cycle && permit;
	endsequence
	sequence s_ref_aborted;
		state_reg == press_seq_pkg::ST_IDLE ##1 irq_status_reg[press_seq_pkg::EV_REF_ERROR];
	endsequence

	property p_ref_order;
		s_ref_fire_end |=> state_reg == press_seq_pkg::ST_REF_HOME;
	endproperty
	a_ref_order: assert property (p_ref_order) else $error("referencing did not move to home after firing");
	property p_ref_abort;
		in_ref && !manual_cycle |=> s_ref_aborted;
	endproperty
	a_ref_abort: assert property (p_ref_abort) else $error("cycle release did not abort referencing");
	property p_ref_zero;
		state_reg == press_seq_pkg::ST_REF_FIRE && press_complete |=> length_reg == 24'h000000 && referenced_reg;
	endproperty
	a_ref_zero: assert property (p_ref_zero) else $error("length not zeroed at stroke bottom");
	property p_run_entry;
		state_reg == press_seq_pkg::ST_IDLE && run_rise && order_loaded_reg && permit && !cycle_rise && !test_go
			|=> state_reg == press_seq_pkg::ST_RUN && run_out;
	endproperty
	a_run_entry: assert property (p_run_entry) else $error("run input did not enter run mode");
	property p_count_down;
		state_reg == press_seq_pkg::ST_FIRE && fire_done && !test_mode_reg && !continuous && left_reg != 16'h0000
			&& !order_load |=> left_reg == $past(left_reg) - 16'h0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("remaining quantity not decremented");
	property p_unit_id;
		1 |=> unit_id_reg == press_seq_pkg::UNIT_ID_BASE +
			{5'h00, $past(cfg_switch_three), $past(cfg_switch_two), $past(cfg_switch_one)};
	endproperty
	a_unit_id: assert property (p_unit_id) else $error("unit identifier does not match switches");
	property p_cut_end;
		state_reg == press_seq_pkg::ST_CUT && press_complete |=> !press_down && state_reg == press_seq_pkg::ST_IDLE;
	endproperty
	a_cut_end: assert property (p_cut_end) else $error("cut output not released on press complete");
	property p_estop;
		!estop_ready |=> !drive_enable && !run_out && state_reg != press_seq_pkg::ST_RUN;
	endproperty
	a_estop: assert property (p_estop) else $error("drive enable or run active with emergency stop open");
endmodule // flying_press_sequencer

// *** verilog/press_seq_pkg.sv ***
// Behaviour
// - Material is tracked only as relative encoder movement, in a length counter given meaning by referencing.
// - A held cycle input seeks the reference switch, moves to minimum die distance, fires, then returns home; with e-stop open or switch seven on it cuts.
// - Releasing the cycle input before referencing ends aborts it and raises an error.
// - At the bottom of the referencing stroke the length counter is cleared and the unit is referenced.
// - A test command carries a part length and velocity, starts on confirm and halts at once on cancel.
// - During the test, line encoder pulses are made at a rate set by the velocity and the die cycles as in a real cut.
// - Raising the run input with an order loaded enters run mode, which counts holes and fires at each target.
// - The remaining quantity drops after each piece and the line stops when it reaches zero.
// - A target already beyond the die when run mode is entered raises a missed-cut error.
// - The unit identifier is 30 plus the three low configuration switches, switch one as the least significant bit.
// - Switch four flips line encoder direction, five the die encoder, six the drive polarity; seven must stay off.
// - Inputs and outputs follow the fixed assignment: jogs, run, press complete, cycle, retract, e-stop; press, enable, run.
// - A target is placed the programmed length beyond the last of the programmed number of counted holes.
// - An order quantity of 9999 runs continuously without counting down.
// - A manual cycle holds the cut output until the hold time expires or press complete closes.
package press_seq_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_QTY = 8'h04;
	localparam logic [7:0] ADDR_HOLES = 8'h08;
	localparam logic [7:0] ADDR_LENGTH = 8'h0C;
	localparam logic [7:0] ADDR_TEST_LEN = 8'h10;
	localparam logic [7:0] ADDR_TEST_VEL = 8'h14;
	localparam logic [7:0] ADDR_HOLD = 8'h18;
	localparam logic [7:0] ADDR_MIN_DIE = 8'h1C;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_POSITION = 8'h24;
	localparam logic [7:0] ADDR_UNIT_ID = 8'h28;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h30;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h34;
	localparam int CTRL_TEST_START = 0;
	localparam int CTRL_TEST_CANCEL = 1;
	localparam int CTRL_ORDER_LOAD = 2;
	localparam int CTRL_CLEAR_HOLES = 3;
	localparam int EV_REF_DONE = 0;
	localparam int EV_REF_ERROR = 1;
	localparam int EV_MISSED_CUT = 2;
	localparam int EV_PIECE_DONE = 3;
	localparam int EV_BATCH_DONE = 4;
	localparam int EV_WIDTH = 5;
	localparam logic [15:0] QTY_CONTINUOUS = 16'd9999;
	localparam logic [7:0] UNIT_ID_BASE = 8'd30;
	localparam logic [15:0] HOLD_MS_RESET = 16'd500;
	localparam logic [23:0] MIN_DIE_RESET = 24'h000100;
	localparam logic [15:0] HOLES_RESET = 16'h0001;
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_PERIOD_NS = 1000000;
	localparam int MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_REF_SEEK = 4'h1,
		ST_REF_MOVE = 4'h2,
		ST_REF_FIRE = 4'h3,
		ST_REF_HOME = 4'h4,
		ST_CUT = 4'h5,
		ST_RUN = 4'h6,
		ST_FIRE = 4'h7,
		ST_RETURN = 4'h8
	} state_type;
endpackage

// *** verilog/pulse_rate_gen.sv ***
`timescale 1ns/1ps
// Phase accumulator: one output pulse per carry, so the pulse rate is rate/65536 of the clock.
module pulse_rate_gen (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [15:0] rate,
	output logic pulse
);
	logic [15:0] acc_reg;
	logic [16:0] sum;
	assign sum = {1'b0, acc_reg} + {1'b0, rate};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_reg <= 16'h0000;
			pulse <= 1'b0;
		end else if (enable) begin
			acc_reg <= sum[15:0];
			pulse <= sum[16];
		end else begin
			acc_reg <= 16'h0000;
			pulse <= 1'b0;
		end
	end
endmodule // pulse_rate_gen

// *** tb/machine_model.sv ***
`timescale 1ns/1ps
// Press and die stand-in: the die moves one encoder step every other cycle while driven.
module machine_model (
	input wire logic sys_clk,
	input wire logic press_down,
	input wire logic die_fwd,
	input wire logic die_rev,
	output logic press_complete,
	output logic die_step,
	output logic die_dir,
	output logic ref_switch,
	output int press_count
);
	int pos = 0;
	int dwell = 0;
	initial begin
		press_complete = 1'b0;
		die_step = 1'b0;
		die_dir = 1'b1;
		ref_switch = 1'b1;
		press_count = 0;
	end
	always @(posedge sys_clk) begin
		die_step <= 1'b0;
		if (!die_step && (die_fwd || die_rev)) begin
			die_step <= 1'b1;
			die_dir <= die_fwd;
			pos = pos + (die_fwd ? 1 : -1);
		end
		ref_switch <= (pos <= 0);
		if (press_down) dwell++;
		else dwell = 0;
		// The stroke bottoms out a few cycles after the press is fired.
		press_complete <= press_down && (dwell >= 3);
		if (press_down && dwell == 1) press_count++;
	end
endmodule // machine_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic sys_clk, rst, wr_stb, rd_stb, irq, run_in, press_complete, manual_cycle, hole_detect, estop_ready;
	logic ref_switch, line_step, die_step, die_dir, sw1, sw2, sw3, spare_switch, jog, pol, lsw;
	logic press_down, drive_enable, run_out, die_fwd, die_rev;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	int presses;
	int num_errors = 0;
	int cmp_count = 0;
	flying_press_sequencer #(.MS_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .die_jog_fwd(jog), .die_jog_rev(1'b0),
		.run_in(run_in), .press_complete(press_complete), .manual_cycle(manual_cycle), .die_retract(1'b0),
		.hole_detect(hole_detect), .estop_ready(estop_ready), .ref_switch(ref_switch), .line_step(line_step),
		.line_dir(1'b1), .die_step(die_step), .die_dir(die_dir), .cfg_switch_one(sw1), .cfg_switch_two(sw2),
		.cfg_switch_three(sw3), .line_encoder_dir_switch(lsw), .die_encoder_dir_switch(1'b0),
		.drive_polarity_switch(pol), .spare_switch(spare_switch), .press_down(press_down),
		.drive_enable(drive_enable), .run_out(run_out), .die_fwd(die_fwd), .die_rev(die_rev));
	machine_model mach_u (.sys_clk(sys_clk), .press_down(press_down), .die_fwd(die_fwd), .die_rev(die_rev),
		.press_complete(press_complete), .die_step(die_step), .die_dir(die_dir), .ref_switch(ref_switch),
		.press_count(presses));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		@(negedge sys_clk);
		q = rdata;
		@(posedge sys_clk);
	endtask
	task automatic wait_event(int b);
		for (int i = 0; i < 3000; i++) begin
			rd(press_seq_pkg::ADDR_IRQ_STATUS);
			if (q[b] === 1'b1) return;
		end
		num_errors++;
		$display("wrong value event wait expected 1 seen 0");
		tally_and_finish();
	endtask
	task automatic t_unit_id();
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			{sw3, sw2, sw1} <= 3'(i);
			repeat (3) @(posedge sys_clk);
			rd(press_seq_pkg::ADDR_UNIT_ID);
			chk("unit_id", 32'(30 + i), q);
		end
		$display("test unit_id done");
	endtask
	task automatic t_estop();
		int p0;
		wr(press_seq_pkg::ADDR_QTY, 32'h00000001);
		wr(press_seq_pkg::ADDR_CTRL, 32'h00000004);
		estop_ready <= 1'b0;
		run_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("drive_enable", 32'h0, 32'(drive_enable));
		chk("run_out", 32'h0, 32'(run_out));
		rd(press_seq_pkg::ADDR_STATUS);
		chk("state", 32'h0, 32'(q[3:0]));
		p0 = presses;
		manual_cycle <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("press_down", 32'h1, 32'(press_down));
		repeat (10) @(posedge sys_clk);
		chk("press_down", 32'h0, 32'(press_down));
		chk("cut_presses", 32'(p0 + 1), 32'(presses));
		manual_cycle <= 1'b0;
		run_in <= 1'b0;
		estop_ready <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("drive_enable", 32'h1, 32'(drive_enable));
		$display("test estop done");
	endtask
	task automatic t_abort();
		wr(press_seq_pkg::ADDR_IRQ_ENABLE, 32'h0000001F);
		manual_cycle <= 1'b1;
		repeat (6) @(posedge sys_clk);
		manual_cycle <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(press_seq_pkg::ADDR_IRQ_STATUS);
		chk("ref_error", 32'h1, 32'(q[press_seq_pkg::EV_REF_ERROR]));
		chk("irq", 32'h1, 32'(irq));
		wr(press_seq_pkg::ADDR_IRQ_CLEAR, 32'h0000001F);
		repeat (3) @(posedge sys_clk);
		chk("irq", 32'h0, 32'(irq));
		$display("test abort done");
	endtask
	task automatic t_jog();
		jog <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("die_fwd", 32'h1, 32'(die_fwd));
		chk("die_rev", 32'h0, 32'(die_rev));
		pol <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk("die_fwd", 32'h0, 32'(die_fwd));
		chk("die_rev", 32'h1, 32'(die_rev));
		{jog, pol, lsw} <= 3'h1;
		repeat (2) begin
			@(posedge sys_clk);
			line_step <= 1'b1;
			@(posedge sys_clk);
			line_step <= 1'b0;
		end
		rd(press_seq_pkg::ADDR_POSITION);
		chk("length", 32'h00FFFFFE, q);
		lsw <= 1'b0;
		$display("test jog done");
	endtask
	task automatic t_test();
		wr(press_seq_pkg::ADDR_IRQ_CLEAR, 32'h0000001F);
		wr(press_seq_pkg::ADDR_TEST_LEN, 32'h00000004);
		wr(press_seq_pkg::ADDR_TEST_VEL, 32'h00004000);
		wr(press_seq_pkg::ADDR_CTRL, 32'h00000001);
		wait_event(press_seq_pkg::EV_PIECE_DONE);
		chk("batch_done", 32'h0, 32'(q[press_seq_pkg::EV_BATCH_DONE]));
		rd(press_seq_pkg::ADDR_STATUS);
		chk("test_mode", 32'h1, 32'(q[6]));
		wr(press_seq_pkg::ADDR_CTRL, 32'h00000002);
		rd(press_seq_pkg::ADDR_STATUS);
		chk("state", 32'h0, 32'(q[3:0]));
		chk("test_mode", 32'h0, 32'(q[6]));
		$display("test sim_run done");
	endtask
	task automatic t_reference();
		int p0;
		p0 = presses;
		wr(press_seq_pkg::ADDR_MIN_DIE, 32'h00000008);
		manual_cycle <= 1'b1;
		wait_event(press_seq_pkg::EV_REF_DONE);
		manual_cycle <= 1'b0;
		chk("ref_presses", 32'(p0 + 1), 32'(presses));
		rd(press_seq_pkg::ADDR_STATUS);
		chk("referenced", 32'h1, 32'(q[5]));
		rd(press_seq_pkg::ADDR_POSITION);
		chk("length", 32'h0, q);
		wr(press_seq_pkg::ADDR_IRQ_CLEAR, 32'h0000001F);
		$display("test reference done");
	endtask
	task automatic t_run();
		wr(press_seq_pkg::ADDR_QTY, 32'h00000001);
		wr(press_seq_pkg::ADDR_HOLES, 32'h00000001);
		wr(press_seq_pkg::ADDR_LENGTH, 32'h00000004);
		wr(press_seq_pkg::ADDR_CTRL, 32'h00000004);
		run_in <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("run_out", 32'h1, 32'(run_out));
		hole_detect <= 1'b1;
		@(posedge sys_clk);
		hole_detect <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk);
			line_step <= 1'b1;
			@(posedge sys_clk);
			line_step <= 1'b0;
		end
		wait_event(press_seq_pkg::EV_BATCH_DONE);
		chk("piece_done", 32'h1, 32'(q[press_seq_pkg::EV_PIECE_DONE]));
		rd(press_seq_pkg::ADDR_STATUS);
		chk("state", 32'h0, 32'(q[3:0]));
		chk("run_out", 32'h0, 32'(run_out));
		run_in <= 1'b0;
		$display("test run done");
	endtask
	initial begin
		rst = 1'b1;
		{addr, wdata, wr_stb, rd_stb, run_in, manual_cycle, hole_detect, line_step} = '0;
		{sw1, sw2, sw3, spare_switch, jog, pol, lsw} = 7'h00;
		estop_ready = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		t_unit_id();
		t_estop();
		t_abort();
		t_jog();
		t_reference();
		t_run();
		t_test();
		tally_and_finish();
	end
endmodule // tb_top
